/* common/mwfs_defines.svh */
// offsets, field positions, reset values and codes of the sequencer
`ifndef MWFS_DEFINES_SVH
`define MWFS_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MWFS_OFF_CTRL 12'h000
`define MWFS_OFF_STAT 12'h004
`define MWFS_OFF_MAR 12'h008
`define MWFS_OFF_RBRLO 12'h00C
`define MWFS_OFF_WCNT 12'h010
`define MWFS_OFF_REG0 12'h020
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MWFS_CTRL_CMD 1:0
`define MWFS_CTRL_GO 2
`define MWFS_CTRL_WKIND 4:3
`define MWFS_CTRL_3D 5
`define MWFS_CTRL_SEL 9:6
`define MWFS_CTRL_RST 10'h000
// ----------------------------------------------------------------
// commands, write kinds, register numbers, cycle kinds
// ----------------------------------------------------------------
`define MWFS_CMD_WRITE 2'h0
`define MWFS_CMD_FETCH 2'h1
`define MWFS_CMD_IND 2'h2
`define MWFS_WK_STACK 2'h0
`define MWFS_WK_STORE 2'h1
`define MWFS_WK_OUT 2'h2
`define MWFS_REG_RAR 3'h0
`define MWFS_REG_WAR 3'h1
`define MWFS_REG_DSP 3'h6
`define MWFS_SEL_DEC 3
`define MWFS_MAP_DWRITE 2
`define MWFS_MAP_DREAD 4
`define MWFS_AW 18
`endif

/* common/mwfs_pkg.sv */
// types shared by the sequencer files
package mwfs_pkg;
  // sequencer steps; idle stands for the mode dispatch step
  typedef enum logic [4:0] {
    S_IDLE, S_WENTRY, S_STK_SET, S_STK_REQ, S_STO_SET, S_STO_REQ,
    S_OUT_SET, S_OUT_REQ, S_WACK, S_F2CHK, S_WAIT1, S_ADDR1,
    S_READ1, S_WAIT2, S_ADDR2, S_READF, S_INDF
  } mwfs_state_t;
  // memory cycle request toward the host memory interface
  typedef struct packed {
    logic req;
    logic [4:0] map;
    logic [17:0] addr;
  } mwfs_mreq_t;
  // latched ahb address phase
  typedef struct packed {
    logic act;
    logic wr;
    logic [11:0] addr;
  } mwfs_aphase_t;
endpackage : mwfs_pkg

/* logic/mwfs_regfile.sv */
// processor register file with registered read port
`timescale 1ns/10ps
module mwfs_regfile #(
  parameter int NREG = 8,
  parameter int AW = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [$clog2(NREG)-1:0] waddr,
  input wire logic [AW-1:0] wdata,
  input wire logic [$clog2(NREG)-1:0] raddr,
  output logic [AW-1:0] rdata_q
);
  logic [AW-1:0] mem [NREG];

  initial begin
    if (NREG < 8 || NREG > 16 || AW < 2) begin
      $error("mwfs_regfile: bad size");
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // array not reset; software loads pointers first
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a flop, a cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule : mwfs_regfile

/* logic/mwfs_seq.sv */
// write and data fetch microcode sequencer with ahb-lite registers
// ----------------------------------------------------------------
// Summary of operation
// [R1] sense flags remember write called from fetch
// [R2] write entry dispatches to three write sequences
// [R3] stack write loads stack pointer into address
// [R4] stack request waits grant, bumps stack pointer
// [R5] store write loads read pointer into address
// [R6] store request waits grant, bumps read pointer
// [R7] output write uses write pointer, counts writes
// [R8] output request waits grant, bumps write pointer
// [R9] ack write; return unless flag one set
// [R10] flag two picks second or first wait
// [R11] fetch one word 2d, two words 3d
// [R12] first wait: set one, clear two, hold
// [R13] second wait sets both flags, else same
// [R14] address from selector; decrement only stack pointer
// [R15] first address loads command; 2d skips ahead
// [R16] read steps stall until read data arrives
// [R17] read writes pointer back, fills buffer, flags
// [R18] second address same, no command load
// [R19] final read clears flags, returns past caller
// [R20] indirect end pokes state machines, back idle
// [R21] pipeline ready only with buffer flag clear
// [R22] memory request held until granted once
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "mwfs_defines.svh"
module mwfs_seq #(
  parameter int NREG = 8,
  parameter int AW = 18,
  parameter int DW = 36
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output mwfs_pkg::mwfs_mreq_t mem_req,
  output logic [DW-1:0] mem_wdata,
  input wire logic mem_grant,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic read_buffer_flag,
  input wire logic write_request,
  input wire logic [DW-1:0] write_buffer_data,
  output logic write_ack,
  output logic out_flag,
  output logic [DW-1:0] read_buffer_reg,
  output logic cmd_load,
  output logic fsm_poke
);
  localparam int RW = $clog2(NREG);

  initial begin
    if (AW != `MWFS_AW || DW < 32 || NREG < 8 || NREG > 16) begin
      $error("mwfs_seq: bad parameters");
    end
  end

  mwfs_pkg::mwfs_state_t state_q, state_d;
  mwfs_pkg::mwfs_aphase_t ap_q;
  mwfs_pkg::mwfs_mreq_t mreq_q;
  logic [9:0] ctrl_q;
  logic go_q;
  logic f1_q, f2_q;
  logic dec_q;
  logic [AW-1:0] mar_q, mar_d;
  logic dec_d;
  logic [DW-1:0] mbr_q, rbr_q, wdat_q;
  logic [AW-1:0] wcnt_q;
  logic [31:0] hrdata_q;
  logic wack_q, oflag_q, cload_q, fpoke_q;
  logic done;
  logic rf_we;
  logic [RW-1:0] rf_waddr, rf_raddr;
  logic [AW-1:0] rf_wdata, rf_rdata;
  logic ahb_rf_we;
  logic [RW-1:0] sel_reg;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register number that a step reads, from the step and selector
  function automatic logic [RW-1:0] reg_of(
    input mwfs_pkg::mwfs_state_t st, input logic [RW-1:0] sel);
    case (st)
      mwfs_pkg::S_STK_SET: reg_of = RW'(`MWFS_REG_DSP);
      mwfs_pkg::S_STO_SET: reg_of = RW'(`MWFS_REG_RAR);
      mwfs_pkg::S_OUT_SET: reg_of = RW'(`MWFS_REG_WAR);
      default: reg_of = sel;
    endcase
  endfunction : reg_of

  // steps that hold a memory cycle request open
  function automatic logic is_req(input mwfs_pkg::mwfs_state_t st);
    case (st)
      mwfs_pkg::S_STK_REQ, mwfs_pkg::S_STO_REQ, mwfs_pkg::S_OUT_REQ,
      mwfs_pkg::S_READ1, mwfs_pkg::S_READF: is_req = 1'b1;
      default: is_req = 1'b0;
    endcase
  endfunction : is_req

  assign sel_reg = RW'(ctrl_q[`MWFS_CTRL_SEL]);
  assign done = mreq_q.req & mem_grant; // [R22]

  // ----------------------------------------------------------------
  // step sequencing
  // ----------------------------------------------------------------
  // next step; a pending write call wins in wait steps
  always_comb begin
    state_d = state_q;
    case (state_q)
      mwfs_pkg::S_IDLE: begin
        if (go_q) begin
          case (ctrl_q[`MWFS_CTRL_CMD])
            `MWFS_CMD_WRITE: state_d = mwfs_pkg::S_WENTRY;
            `MWFS_CMD_FETCH: state_d = mwfs_pkg::S_WAIT1;
            `MWFS_CMD_IND: state_d = mwfs_pkg::S_INDF;
            default: state_d = mwfs_pkg::S_IDLE;
          endcase
        end
      end
      mwfs_pkg::S_WENTRY: begin
        case (ctrl_q[`MWFS_CTRL_WKIND]) // [R2]
          `MWFS_WK_STACK: state_d = mwfs_pkg::S_STK_SET;
          `MWFS_WK_STORE: state_d = mwfs_pkg::S_STO_SET;
          default: state_d = mwfs_pkg::S_OUT_SET;
        endcase
      end
      mwfs_pkg::S_STK_SET: state_d = mwfs_pkg::S_STK_REQ; // [R3]
      mwfs_pkg::S_STO_SET: state_d = mwfs_pkg::S_STO_REQ; // [R5]
      mwfs_pkg::S_OUT_SET: state_d = mwfs_pkg::S_OUT_REQ; // [R7]
      mwfs_pkg::S_STK_REQ, mwfs_pkg::S_STO_REQ,
      mwfs_pkg::S_OUT_REQ: begin
        if (done) begin
          state_d = mwfs_pkg::S_WACK; // [R4] [R6] [R8]
        end
      end
      mwfs_pkg::S_WACK: begin
        // one return level only: flags say fetch was the caller
        state_d = f1_q ? mwfs_pkg::S_F2CHK : mwfs_pkg::S_IDLE; // [R9] [R1]
      end
      mwfs_pkg::S_F2CHK: begin
        state_d = f2_q ? mwfs_pkg::S_WAIT2 : mwfs_pkg::S_WAIT1; // [R10]
      end
      mwfs_pkg::S_WAIT1, mwfs_pkg::S_WAIT2: begin
        if (write_request) begin
          state_d = mwfs_pkg::S_WENTRY; // [R12]
        end else if (!read_buffer_flag) begin // [R21]
          state_d = (state_q == mwfs_pkg::S_WAIT1) ?
                    mwfs_pkg::S_ADDR1 : mwfs_pkg::S_ADDR2;
        end
      end
      mwfs_pkg::S_ADDR1: begin
        state_d = ctrl_q[`MWFS_CTRL_3D] ?
                  mwfs_pkg::S_READ1 : mwfs_pkg::S_READF; // [R15] [R11]
      end
      mwfs_pkg::S_READ1: begin
        if (done) begin
          state_d = mwfs_pkg::S_WAIT2; // [R16]
        end
      end
      mwfs_pkg::S_ADDR2: state_d = mwfs_pkg::S_READF; // [R18]
      mwfs_pkg::S_READF: begin
        if (done) begin
          state_d = mwfs_pkg::S_IDLE; // [R19] [R16]
        end
      end
      mwfs_pkg::S_INDF: state_d = mwfs_pkg::S_IDLE; // [R20]
      default: state_d = mwfs_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= mwfs_pkg::S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // sense flags
  // ----------------------------------------------------------------
  // set while waiting for the pipeline, cleared by the final read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f1_q <= 1'b0;
      f2_q <= 1'b0;
    end else begin
      case (state_q)
        mwfs_pkg::S_WAIT1: begin
          f1_q <= 1'b1; // [R12] [R1]
          f2_q <= 1'b0;
        end
        mwfs_pkg::S_WAIT2: begin
          f1_q <= 1'b1; // [R13] [R1]
          f2_q <= 1'b1;
        end
        mwfs_pkg::S_READF: begin
          if (done) begin
            f1_q <= 1'b0; // [R19]
            f2_q <= 1'b0;
          end
        end
        default: f1_q <= f1_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory address register and write counter
  // ----------------------------------------------------------------
  // register data is ready on entry, read address follows state_d;
  // the request takes mar_d so it never carries a stale address
  always_comb begin
    mar_d = mar_q;
    dec_d = dec_q;
    case (state_q)
      mwfs_pkg::S_STK_SET, mwfs_pkg::S_STO_SET,
      mwfs_pkg::S_OUT_SET: begin
        mar_d = rf_rdata; // [R3] [R5] [R7]
        dec_d = 1'b0;
      end
      mwfs_pkg::S_ADDR1, mwfs_pkg::S_ADDR2: begin
        // pop only off the stack pointer
        dec_d = ctrl_q[6 + `MWFS_SEL_DEC] &&
                sel_reg == RW'(`MWFS_REG_DSP);
        mar_d = dec_d ? rf_rdata - AW'(1) : rf_rdata; // [R14] [R18]
      end
      default: mar_d = mar_q;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mar_q <= '0;
      dec_q <= 1'b0;
    end else begin
      mar_q <= mar_d;
      dec_q <= dec_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt_q <= '0;
    end else if (state_q == mwfs_pkg::S_OUT_SET) begin
      wcnt_q <= wcnt_q + AW'(1); // [R7]
    end
  end

  // ----------------------------------------------------------------
  // memory cycle request
  // ----------------------------------------------------------------
  // request follows the next step so it drops the edge after grant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mreq_q <= '0;
      wdat_q <= '0;
    end else begin
      mreq_q.req <= is_req(state_d); // [R22] [R4] [R6] [R8]
      mreq_q.addr <= mar_d;
      mreq_q.map <= '0;
      if (state_d == mwfs_pkg::S_READ1 ||
          state_d == mwfs_pkg::S_READF) begin
        mreq_q.map[`MWFS_MAP_DREAD] <= 1'b1; // [R17]
      end else if (is_req(state_d)) begin
        mreq_q.map[`MWFS_MAP_DWRITE] <= 1'b1; // [R4] [R6] [R8]
      end
      if (is_req(state_d) && !is_req(state_q)) begin
        wdat_q <= write_buffer_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data path toward the pipeline
  // ----------------------------------------------------------------
  // read steps finish on grant, which carries the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mbr_q <= '0;
      rbr_q <= '0;
      oflag_q <= 1'b0;
    end else begin
      oflag_q <= 1'b0;
      if (done && mreq_q.map[`MWFS_MAP_DREAD]) begin
        mbr_q <= mem_rdata; // [R16]
        rbr_q <= mem_rdata; // [R17]
        oflag_q <= 1'b1; // [R17] [R11]
      end
    end
  end

  // one-cycle strobes to the pipeline and write buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wack_q <= 1'b0;
      cload_q <= 1'b0;
      fpoke_q <= 1'b0;
    end else begin
      wack_q <= (state_q == mwfs_pkg::S_WACK); // [R9]
      cload_q <= (state_q == mwfs_pkg::S_ADDR1); // [R15]
      fpoke_q <= (state_q == mwfs_pkg::S_INDF); // [R20]
    end
  end

  // ----------------------------------------------------------------
  // register file port sharing
  // ----------------------------------------------------------------
  // sequencer writes back on grant; software only while idle
  assign ahb_rf_we = ap_q.act && ap_q.wr &&
    state_q == mwfs_pkg::S_IDLE && ap_q.addr[11:5] == 7'h01 &&
    32'(ap_q.addr[4:2]) < NREG;
  always_comb begin
    rf_we = 1'b0;
    rf_waddr = sel_reg;
    rf_wdata = mar_q + AW'(1);
    case (state_q)
      mwfs_pkg::S_STK_REQ: begin
        rf_we = done; // [R4]
        rf_waddr = RW'(`MWFS_REG_DSP);
      end
      mwfs_pkg::S_STO_REQ: begin
        rf_we = done; // [R6]
        rf_waddr = RW'(`MWFS_REG_RAR);
      end
      mwfs_pkg::S_OUT_REQ: begin
        rf_we = done; // [R8]
        rf_waddr = RW'(`MWFS_REG_WAR);
      end
      mwfs_pkg::S_READ1, mwfs_pkg::S_READF: begin
        rf_we = done; // [R17]
        rf_wdata = dec_q ? mar_q : mar_q + AW'(1);
      end
      default: begin
        rf_we = ahb_rf_we;
        rf_waddr = RW'(ap_q.addr[4:2]);
        rf_wdata = hwdata[AW-1:0];
      end
    endcase
    rf_raddr = reg_of(state_d, sel_reg);
  end

  mwfs_regfile #(.NREG(NREG), .AW(AW)) u_regs (
    .clk(hclk),
    .rst_n(hresetn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata_q(rf_rdata)
  );

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait: read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      hrdata_q <= '0;
    end else begin
      ap_q.act <= hsel && htrans[1] && hready && hsize == 3'h2;
      ap_q.wr <= hwrite;
      ap_q.addr <= haddr[11:0];
      hrdata_q <= '0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[11:0])
          `MWFS_OFF_CTRL: hrdata_q <= 32'(ctrl_q);
          `MWFS_OFF_STAT: hrdata_q <= {24'h00_0000,
            state_q != mwfs_pkg::S_IDLE, f2_q, f1_q, state_q};
          `MWFS_OFF_MAR: hrdata_q <= 32'(mar_q);
          `MWFS_OFF_RBRLO: hrdata_q <= rbr_q[31:0];
          `MWFS_OFF_WCNT: hrdata_q <= 32'(wcnt_q);
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; go taken only while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `MWFS_CTRL_RST;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (ap_q.act && ap_q.wr && ap_q.addr == `MWFS_OFF_CTRL &&
          state_q == mwfs_pkg::S_IDLE && !go_q) begin
        ctrl_q <= hwdata[9:0];
        ctrl_q[`MWFS_CTRL_GO] <= 1'b0;
        go_q <= hwdata[`MWFS_CTRL_GO];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign mem_req = mreq_q;
  assign mem_wdata = wdat_q;
  assign write_ack = wack_q;
  assign out_flag = oflag_q;
  assign read_buffer_reg = rbr_q;
  assign cmd_load = cload_q;
  assign fsm_poke = fpoke_q;
endmodule : mwfs_seq

/* tb/mwfs_seq_checker.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module mwfs_seq_checker #(
  parameter int DW = 36
) (
  input wire logic hclk,
  input wire logic hresetn,
  input mwfs_pkg::mwfs_mreq_t mem_req,
  input wire logic mem_grant,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic write_ack,
  input wire logic out_flag,
  input wire logic [DW-1:0] read_buffer_reg,
  input wire logic cmd_load,
  input wire logic fsm_poke
);
  // ----------------------------------------------------------------
  // memory handshake and pipeline pulses
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_g;
  logic wr_g;
  // granted read and write cycles
  assign rd_g = mem_req.req && mem_grant && mem_req.map[4];
  assign wr_g = mem_req.req && mem_grant && mem_req.map[2];
  a_req_held: assert property (mem_req.req && !mem_grant |=> $stable(mem_req))
    else $error("request moved before its grant");
  a_req_drop: assert property (mem_req.req && mem_grant |=> !mem_req.req)
    else $error("request still up after grant");
  a_read_out: assert property (rd_g |=> out_flag)
    else $error("no output flag after read");
  a_read_load: assert property (rd_g |=> read_buffer_reg == $past(mem_rdata))
    else $error("read buffer not loaded from memory");
  a_out_cause: assert property (out_flag |-> $past(rd_g))
    else $error("output flag without read grant");
  a_write_ack: assert property (wr_g |-> ##2 write_ack)
    else $error("write not acknowledged");
  a_ack_cause: assert property (write_ack |-> $past(wr_g, 2))
    else $error("acknowledge without write");
  a_map_kind: assert property (mem_req.req |->
    (mem_req.map == 5'h04 || mem_req.map == 5'h10))
    else $error("bad cycle kind bits");
  a_poke_pulse: assert property (fsm_poke |=> !fsm_poke && !mem_req.req)
    else $error("state machine poke not single");
  c_read: cover property (rd_g);
  c_write: cover property (wr_g);
  c_cmd: cover property (cmd_load);
  c_poke: cover property (fsm_poke);
endmodule : mwfs_seq_checker

bind mwfs_seq mwfs_seq_checker #(.DW(DW)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
  .mem_grant(mem_grant), .mem_rdata(mem_rdata), .write_ack(write_ack),
  .out_flag(out_flag), .read_buffer_reg(read_buffer_reg),
  .cmd_load(cmd_load), .fsm_poke(fsm_poke)
);

/* tb/mwfs_far_model.sv */
// host memory and pipeline stand-in facing the sequencer
`timescale 1ns/10ps
module mwfs_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input mwfs_pkg::mwfs_mreq_t mem_req,
  output logic mem_grant,
  output logic [35:0] mem_rdata,
  input wire logic out_flag,
  input wire logic kick,
  input wire logic hold,
  output logic read_buffer_flag,
  output logic write_request
);
  logic [1:0] dly_q;
  logic [2:0] spell_q;
  logic [35:0] word;
  // ----------------------------------------------------------------
  // memory side
  // ----------------------------------------------------------------
  // random grant latency, one grant pulse per request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_grant <= 1'b0;
      dly_q <= 2'h0;
    end else if (mem_grant) begin
      mem_grant <= 1'b0;
      dly_q <= 2'($urandom_range(3));
    end else if (mem_req.req) begin
      if (dly_q == 2'h0) mem_grant <= 1'b1;
      else dly_q <= dly_q - 2'h1;
    end
  end
  // inverted outside the grant cycle so stale data never matches
  assign word = {mem_req.addr ^ 18'h2_5a5a, mem_req.addr};
  assign mem_rdata = mem_grant ? word : ~word;
  // ----------------------------------------------------------------
  // pipeline side
  // ----------------------------------------------------------------
  // busy a random spell after each word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) spell_q <= 3'h0;
    else if (out_flag) spell_q <= 3'($urandom_range(4, 1));
    else if (spell_q != 3'h0) spell_q <= spell_q - 3'h1;
  end
  assign read_buffer_flag = hold || out_flag || spell_q != 3'h0;
  // write pending until its grant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) write_request <= 1'b0;
    else if (kick) write_request <= 1'b1;
    else if (mem_grant && mem_req.map[2]) write_request <= 1'b0;
  end
endmodule : mwfs_far_model

/* tb/microcode_write_fetch_seq_tb_top.sv */
// bench for the write and fetch sequencer
`timescale 1ns/10ps
`include "mwfs_defines.svh"
module microcode_write_fetch_seq_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [35:0] wbd = 36'h0_0000_0000;
  logic kick = 1'b0;
  logic hold = 1'b0;
  logic hready, hreadyout, hresp, mem_grant, read_buffer_flag;
  logic write_request, write_ack, out_flag, cmd_load, fsm_poke, d3r;
  logic [31:0] hrdata, r;
  logic [35:0] mem_wdata, mem_rdata, read_buffer_reg;
  mwfs_pkg::mwfs_mreq_t mem_req;
  logic [17:0] rv [8];
  logic [58:0] exp_q [$];
  logic [58:0] e;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_ack = 0, n_out = 0, n_cmd = 0, n_poke = 0;
  int e_ack = 0, e_out = 0, e_cmd = 0, e_poke = 0, e_wcnt = 0;

  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  mwfs_seq dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_req(mem_req), .mem_wdata(mem_wdata),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata),
    .read_buffer_flag(read_buffer_flag), .write_request(write_request),
    .write_buffer_data(wbd), .write_ack(write_ack), .out_flag(out_flag),
    .read_buffer_reg(read_buffer_reg), .cmd_load(cmd_load),
    .fsm_poke(fsm_poke)
  );
  mwfs_far_model far (
    .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata), .out_flag(out_flag),
    .kick(kick), .hold(hold), .read_buffer_flag(read_buffer_flag),
    .write_request(write_request)
  );

  // ----------------------------------------------------------------
  // compare, verdict, bus master
  // ----------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] want);
    n_checks++;
    if (got !== want) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic results;
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // one word transfer; read data into r
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    chk(36'(hresp), 36'h0);
  endtask : ahb

  // poll until idle; flags must then be clear
  task automatic go(input logic [1:0] cmd, input logic [1:0] wk,
                    input logic d3, input logic [3:0] sel);
    ahb(1'b1, `MWFS_OFF_CTRL, {22'h0, sel, d3, wk, 1'b1, cmd});
    r = 32'hffff_ffff;
    for (int i = 0; i < 200 && r[7] !== 1'b0; i++)
      ahb(1'b0, `MWFS_OFF_STAT, 32'h0);
    chk(36'(r[7:0]), 36'h0);
  endtask : go

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  task automatic exp_write(input logic [1:0] wk, input logic [35:0] v);
    int n;
    n = (wk == `MWFS_WK_STACK) ? 6 : (wk == `MWFS_WK_STORE) ? 0 : 1;
    exp_q.push_back({5'h04, rv[n], v});
    rv[n] = rv[n] + 18'h1;
    e_ack++;
    if (n == 1) e_wcnt++;
  endtask : exp_write

  task automatic do_write(input logic [1:0] wk);
    logic [35:0] v;
    v = {4'($urandom), $urandom};
    wbd <= v;
    exp_write(wk, v);
    go(`MWFS_CMD_WRITE, wk, 1'b0, 4'h0);
  endtask : do_write

  // kk: pending write before word kk (0 none)
  task automatic do_fetch(input logic [1:0] wk, input logic d3,
                          input logic [3:0] sel, input logic [1:0] kk);
    logic [17:0] a;
    logic [35:0] v;
    logic dec;
    v = {4'($urandom), $urandom};
    dec = sel[3] && sel[2:0] == `MWFS_REG_DSP;
    wbd <= v;
    kick <= (kk == 2'h1);
    for (int k = 0; k <= int'(d3); k++) begin
      if (kk == 2'(k + 1)) exp_write(wk, v);
      a = dec ? rv[6] - 18'h1 : rv[sel[2:0]];
      exp_q.push_back({5'h10, a, 36'h0});
      rv[sel[2:0]] = dec ? a : a + 18'h1;
    end
    e_out += int'(d3) + 1;
    e_cmd++;
    @(posedge hclk);
    kick <= 1'b0;
    fork
      go(`MWFS_CMD_FETCH, wk, d3, sel);
      if (kk == 2'h2) begin
        @(posedge hclk iff out_flag === 1'b1);
        kick <= 1'b1;
        @(posedge hclk);
        kick <= 1'b0;
      end
    join
    chk(read_buffer_reg, {a ^ 18'h2_5a5a, a});
    ahb(1'b0, `MWFS_OFF_MAR, 32'h0);
    chk(36'(r[17:0]), 36'(a));
  endtask : do_fetch

  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  // each grant matches the next expected cycle
  always @(posedge hclk) begin
    if (hresetn && mem_req.req && mem_grant) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
      chk(36'({mem_req.map, mem_req.addr}), 36'(e[58:36]));
      if (e[56]) chk(mem_wdata, e[35:0]);
    end
    n_ack += int'(write_ack);
    n_out += int'(out_flag);
    n_cmd += int'(cmd_load);
    n_poke += int'(fsm_poke);
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h617b_a529));
    for (int i = 0; i < 8; i++) rv[i] = 18'($urandom);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `MWFS_OFF_CTRL, 32'h0);
    chk(36'(r), 36'(`MWFS_CTRL_RST));
    ahb(1'b0, 12'h018, 32'h0);
    chk(36'(r), 36'h0);
    for (int i = 0; i < 8; i++)
      ahb(1'b1, 12'(`MWFS_OFF_REG0 + 4 * i), 32'(rv[i]));
    // each write kind code twice; code 3 also takes the output write
    for (int k = 0; k < 8; k++) do_write(2'(k / 2));
    do_fetch(`MWFS_WK_STACK, 1'b1, 4'he, 2'h1);
    do_fetch(`MWFS_WK_OUT, 1'b1, 4'h9, 2'h2);
    do_fetch(`MWFS_WK_STORE, 1'b0, 4'h6, 2'h0);
    // register writes while busy are dropped
    hold <= 1'b1;
    exp_q.push_back({5'h10, rv[0], 36'h0});
    rv[0] = rv[0] + 18'h1;
    e_out++;
    e_cmd++;
    ahb(1'b1, `MWFS_OFF_CTRL, 32'h0000_0005);
    ahb(1'b1, `MWFS_OFF_REG0, 32'h0001_2345);
    fork
      go(`MWFS_CMD_FETCH, 2'h0, 1'b0, 4'h0);
      begin
        repeat (8) @(posedge hclk);
        hold <= 1'b0;
      end
    join
    for (int j = 0; j < 12; j++) begin
      d3r = 1'($urandom);
      do_write(2'($urandom));
      do_fetch(2'($urandom), d3r, 4'($urandom),
               2'($urandom_range(d3r ? 2 : 1)));
    end
    go(`MWFS_CMD_IND, 2'h0, 1'b0, 4'h0);
    e_poke++;
    chk(36'(n_ack), 36'(e_ack));
    chk(36'(n_out), 36'(e_out));
    chk(36'(n_cmd), 36'(e_cmd));
    chk(36'(n_poke), 36'(e_poke));
    chk(36'(exp_q.size()), 36'h0);
    ahb(1'b0, `MWFS_OFF_WCNT, 32'h0);
    chk(36'(r), 36'(e_wcnt));
    results();
  end
endmodule : microcode_write_fetch_seq_tb_top
